// file: bench/testbench.sv
// Self-checking bench for the deserializer video output stage.
`timescale 1ns/100ps
module testbench;
	logic        clock, nrst, power_down_n, link_clock, pll_locked;
	logic        self_test_enable, hold_outputs_low, hold_release;
	logic        rx_valid, rx_ready, rx_error, rx_de, rx_hs, rx_vs;
	logic [7:0]  rx_red, rx_green, rx_blue, strap_blue;
	logic [7:0]  red_in, red_out, red_oe, green_in, green_out, green_oe;
	logic [7:0]  blue_in, blue_out, blue_oe;
	logic        video_valid_out, line_sync_out, frame_sync_out, pixel_clock_out;
	logic        ctl_oe, lock_out, pass_out, sleep_state_select, strobe_edge_select;
	logic [1:0]  op_mode;
	logic        full_seen;
	logic [15:0] skew_count;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          de_len, de_n, hs_n;

	// Colour pins resolve against the board: pulldowns everywhere, pullups only on blue.
	assign red_in   = red_oe & red_out;
	assign green_in = green_oe & green_out;
	assign blue_in  = (blue_oe & blue_out) | (~blue_oe & strap_blue);

	deser_video_out dut (
		.clock(clock), .nrst(nrst), .power_down_n(power_down_n), .link_clock(link_clock),
		.pll_locked(pll_locked), .self_test_enable(self_test_enable),
		.hold_outputs_low(hold_outputs_low), .hold_release(hold_release),
		.rx_red(rx_red), .rx_green(rx_green), .rx_blue(rx_blue), .rx_de(rx_de),
		.rx_hs(rx_hs), .rx_vs(rx_vs), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_error(rx_error), .red_in(red_in), .red_out(red_out), .red_oe(red_oe),
		.green_in(green_in), .green_out(green_out), .green_oe(green_oe),
		.blue_in(blue_in), .blue_out(blue_out), .blue_oe(blue_oe),
		.video_valid_out(video_valid_out), .line_sync_out(line_sync_out),
		.frame_sync_out(frame_sync_out), .pixel_clock_out(pixel_clock_out),
		.ctl_oe(ctl_oe), .lock_out(lock_out), .pass_out(pass_out), .op_mode(op_mode),
		.sleep_state_select(sleep_state_select), .strobe_edge_select(strobe_edge_select)
	);

	video_sink_model sink (
		.clock(clock), .pixel_clock(pixel_clock_out), .strobe_rising(strobe_edge_select),
		.active(lock_out & ctl_oe),
		.word({red_out, green_out, blue_out, video_valid_out, line_sync_out, frame_sync_out}),
		.skew_count(skew_count)
	);

	// Core clock, and a link clock with an odd offset so the two never share a phase.
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end
	initial begin
		link_clock = 1'h0;
		#1.3;
		forever #24 link_clock = ~link_clock;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// Offers one pixel word and holds it until the FIFO takes it at the next rising edge.
	task automatic push(input int idx);
		int n;
		n = 0;
		rx_red   = 8'(idx);
		rx_green = 8'(~idx);
		rx_blue  = 8'(idx) ^ 8'h5a;
		rx_de    = (idx >= 30) && (idx < 30 + de_len);
		rx_hs    = (idx >= 60) && (idx < 64);
		rx_vs    = (idx >= 100);
		rx_valid = 1'h1;
		if (rx_ready !== 1'h1)
			full_seen = 1'h1;
		while (rx_ready !== 1'h1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		if (n == 400) begin
			miscompares++;
			finish_test();
		end
		@(negedge clock);
	endtask : push

	// Sends 120 words far faster than the link drains them, then checks what the sink saw.
	task automatic stream(input int len);
		int n;
		video_out_pkg::pixel_word_t w;
		n = 0;
		de_n = 0;
		hs_n = 0;
		de_len = len;
		full_seen = 1'h0;
		sink.log_q.delete();
		for (int i = 1; i <= 120; i++)
			push(i);
		rx_valid = 1'h0;
		while ((sink.log_q.size() == 0 || sink.log_q[$].red !== 8'h78) && n < 600) begin
			@(negedge clock);
			n++;
		end
		if (n == 600) begin
			miscompares++;
			finish_test();
		end
		for (int i = 0; i < sink.log_q.size(); i++) begin
			w = sink.log_q[i];
			if (w != '0) begin
				check("green", w.green, 8'(~w.red));
				check("blue", w.blue, w.red ^ 8'h5a);
				if (i > 0 && sink.log_q[i-1] != '0)
					check("order", w.red, 8'(sink.log_q[i-1].red + 8'h1));
				de_n += w.de;
				hs_n += w.hs;
			end
		end
		check("fifo full", full_seen, 1'h1);
		check("last vs", w.vs, 1'h1);
		check("skew", skew_count, 16'h0);
	endtask : stream

	// Leaves power-down with the given straps and waits through strap sampling and lock.
	task automatic power_up(input logic [7:0] s, input logic hold);
		strap_blue = s;
		hold_outputs_low = hold;
		power_down_n = 1'h1;
		repeat (10) @(negedge clock);
		check("strap oe", blue_oe, 8'h0);
		repeat (30) @(negedge clock);
		check("mode", op_mode, {s[6], s[7]});
		check("sleep sel", sleep_state_select, s[2]);
		check("edge sel", strobe_edge_select, s[1]);
		check("lock low", lock_out, 1'h0);
		check("sleep oe", blue_oe, {8{s[2]}});
		check("sleep red", red_out, 8'h0);
		pll_locked = 1'h1;
		repeat (6) @(negedge clock);
		check("lock", lock_out, 1'h1);
		check("ctl oe", ctl_oe, 1'h1);
	endtask : power_up

	task automatic power_down(input logic exp_sleep);
		power_down_n = 1'h0;
		pll_locked = 1'h0;
		repeat (6) @(negedge clock);
		check("pd lock", lock_out, 1'h0);
		check("pd oe", blue_oe, {8{exp_sleep}});
		check("pd clock", pixel_clock_out, 1'h0);
	endtask : power_down

	// Main sequence: plain mode, filtered mode with hold-low, legacy modes, self-test.
	initial begin
		{nrst, power_down_n, pll_locked, self_test_enable, hold_outputs_low} = 5'h0;
		{hold_release, rx_valid, rx_error, rx_de, rx_hs, rx_vs} = 6'h0;
		{rx_red, rx_green, rx_blue, strap_blue} = 32'h0;
		de_len = 1;
		full_seen = 1'h0;
		repeat (12) @(negedge clock);
		check("reset pass", pass_out, 1'h1);
		check("reset oe", ctl_oe, 1'h0);
		nrst = 1'h1;
		power_up(8'h04, 1'h0);
		stream(1);
		check("de short", de_n, 1);
		check("hs pulse", hs_n, 4);
		power_down(1'h1);
		power_up(8'h82, 1'h1);
		repeat (30) @(negedge clock);
		check("hold lock", lock_out, 1'h1);
		check("hold oe", red_oe, 8'hff);
		check("hold data", {red_out, pixel_clock_out}, 9'h0);
		hold_release = 1'h1;
		@(negedge clock);
		hold_release = 1'h0;
		stream(4);
		check("de filtered", de_n != 0, 1'h1);
		pll_locked = 1'h0;
		repeat (6) @(negedge clock);
		check("unlock", {lock_out, ctl_oe, pixel_clock_out}, 3'h0);
		power_down(1'h0);
		power_up(8'h40, 1'h0);
		power_down(1'h0);
		power_up(8'hc0, 1'h0);
		self_test_enable = 1'h1;
		repeat (5) @(negedge clock);
		check("pass on", pass_out, 1'h1);
		rx_error = 1'h1;
		@(negedge clock);
		rx_error = 1'h0;
		repeat (2) @(negedge clock);
		check("pass err", pass_out, 1'h0);
		self_test_enable = 1'h0;
		repeat (5) @(negedge clock);
		check("pass off", pass_out, 1'h1);
		finish_test();
	end

	// Watchdog: a run that outlives its budget counts as a mismatch.
	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		finish_test();
	end
endmodule : testbench

// file: bench/video_sink_model.sv
// Display-side sink model that captures pixel words on the selected pixel clock edge.
`timescale 1ns/100ps
module video_sink_model (
	input  wire logic                        clock,
	input  wire logic                        pixel_clock,
	input  wire logic                        strobe_rising,
	input  wire logic                        active,
	input  wire video_out_pkg::pixel_word_t  word,
	output logic [15:0]                      skew_count
);
	video_out_pkg::pixel_word_t  log_q[$];
	video_out_pkg::pixel_word_t  word_q;
	logic                        pclk_q;
	logic                        act_q;
	logic                        sel_edge;

	initial skew_count = 16'h0;

	// A selected edge is the pixel clock reaching the level that the edge select names.
	assign sel_edge = (pixel_clock == strobe_rising) && (pclk_q != strobe_rising);

	// The core clock oversamples the pins, so a word that moves without its edge is seen.
	// Repeated words are logged once, which hides a stall but never a skipped word.
	always @(posedge clock) begin
		pclk_q <= pixel_clock;
		act_q  <= active;
		word_q <= word;
		if (active && act_q && word != word_q && !sel_edge)
			skew_count <= skew_count + 16'h1;
		if (active && sel_edge && (log_q.size() == 0 || log_q[$] != word))
			log_q.push_back(word);
	end
endmodule : video_sink_model

// file: hw/deser_video_out.sv
// Deserializer parallel video output stage with straps, lock and self-test.
//
// Functional notes
// - Red, green, blue each on own 8-bit bus, bit 7 most significant.
// - Power-down low forces all video outputs to the sleep-state selection.
// - Colour pins act as inputs during power up for strap reading.
// - All straps sampled at power up; open pins read low by pulldown.
// - Filter off: DE and HS pass with no minimum pulse width.
// - Lock output high only when PLL locked; video driven only then. Sleep select 1 also drives the pins low while unlocked.
// - Unlocked: lock low and outputs held in the sleep-state selection.
// - Self-test pass high while error free, low once an error seen.
// - Data and controls launch relative to the selected pixel clock edge.
// - Edge select 1 uses rising pixel clock edge, 0 the falling edge.
// - Mode 00 filter off, 01 filter on, 10 and 11 older partners.
// - Hold-low option keeps outputs low after lock until released.
// - Self-test enable high enables self-test, low disables it.
`timescale 1ns/100ps
`include "video_out_defs.svh"
module deser_video_out (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        power_down_n,
	input  wire logic        link_clock,
	input  wire logic        pll_locked,
	input  wire logic        self_test_enable,
	input  wire logic        hold_outputs_low,
	input  wire logic        hold_release,
	input  wire logic [7:0]  rx_red,
	input  wire logic [7:0]  rx_green,
	input  wire logic [7:0]  rx_blue,
	input  wire logic        rx_de,
	input  wire logic        rx_hs,
	input  wire logic        rx_vs,
	input  wire logic        rx_valid,
	output wire logic        rx_ready,
	input  wire logic        rx_error,
	input  wire logic [7:0]  red_in,
	output wire logic [7:0]  red_out,
	output wire logic [7:0]  red_oe,
	input  wire logic [7:0]  green_in,
	output wire logic [7:0]  green_out,
	output wire logic [7:0]  green_oe,
	input  wire logic [7:0]  blue_in,
	output wire logic [7:0]  blue_out,
	output wire logic [7:0]  blue_oe,
	output wire logic        video_valid_out,
	output wire logic        line_sync_out,
	output wire logic        frame_sync_out,
	output wire logic        pixel_clock_out,
	output wire logic        ctl_oe,
	output wire logic        lock_out,
	output wire logic        pass_out,
	output wire logic [1:0]  op_mode,
	output wire logic        sleep_state_select,
	output wire logic        strobe_edge_select
);
	localparam int WW = $bits(video_out_pkg::pixel_word_t);

	// Two-stage synchronisers for every pin-side input except hold_release, which is used unsynchronised.
	logic [28:0] sync1_q;
	logic [28:0] sync2_q;
	logic        link_prev_q;
	wire  [28:0] pins_raw = {power_down_n, link_clock, pll_locked, self_test_enable,
	                         hold_outputs_low, red_in, green_in, blue_in};
	wire         pd_s     = sync2_q[28];
	wire         link_s   = sync2_q[27];
	wire         pll_s    = sync2_q[26];
	wire         bist_s   = sync2_q[25];
	wire         hold_s   = sync2_q[24];
	wire  [7:0]  blue_s   = sync2_q[7:0];

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync1_q     <= '0;
			sync2_q     <= '0;
			link_prev_q <= 1'b0;
		end else begin
			sync1_q     <= pins_raw;
			sync2_q     <= sync1_q;
			link_prev_q <= link_s;
		end
	end

	// Edge finding on the sampled link clock; the chosen edge launches a word.
	logic strobe_q;
	wire  link_rise = link_s & ~link_prev_q;
	wire  link_fall = ~link_s & link_prev_q;
	wire  sel_edge  = strobe_q ? link_rise : link_fall;

	// Sequencer.
	video_out_pkg::ctl_state_t state_q;
	video_out_pkg::ctl_state_t state_d;
	logic [7:0] settle_q;
	logic [1:0] mode_q;
	logic       sleep_q;
	logic       hold_q;
	logic       released_q;
	wire        settle_done = (settle_q == 8'(`STRAP_SETTLE_CYC - 1));

	// Next state; power-down and loss of lock override everything.
	always_comb begin
		state_d = state_q;
		case (state_q)
			video_out_pkg::ST_OFF: begin
				state_d = video_out_pkg::ST_STRAP;
			end
			video_out_pkg::ST_STRAP: begin
				if (settle_done) begin
					state_d = video_out_pkg::ST_WAIT_LOCK;
				end
			end
			video_out_pkg::ST_WAIT_LOCK: begin
				if (pll_s) begin
					state_d = (hold_q && !released_q) ? video_out_pkg::ST_HOLD_LOW
					                                  : video_out_pkg::ST_ACTIVE;
				end
			end
			video_out_pkg::ST_HOLD_LOW: begin
				if (released_q || hold_release) begin
					state_d = video_out_pkg::ST_ACTIVE;
				end
			end
			video_out_pkg::ST_ACTIVE: begin
				state_d = video_out_pkg::ST_ACTIVE;
			end
			default: begin
				state_d = video_out_pkg::ST_OFF;
			end
		endcase
		if (!pd_s) begin
			state_d = video_out_pkg::ST_OFF;
		end else if (!pll_s && (state_q == video_out_pkg::ST_HOLD_LOW ||
		                        state_q == video_out_pkg::ST_ACTIVE)) begin
			state_d = video_out_pkg::ST_WAIT_LOCK;
		end
	end

	// Drive decisions for the next cycle. While strapping the colour pins float.
	wire linked_d = (state_d == video_out_pkg::ST_ACTIVE) ||
	                (state_d == video_out_pkg::ST_HOLD_LOW);
	wire sleep_d  = (state_d == video_out_pkg::ST_OFF) ||
	                (state_d == video_out_pkg::ST_WAIT_LOCK);
	wire oe_d     = linked_d || (sleep_d && sleep_q);

	logic lock_q;
	logic oe_q;

	// Straps are latched from synchronised pins at the end of the settle time.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q    <= video_out_pkg::ST_OFF;
			settle_q   <= '0;
			mode_q     <= `MODE_FILTER_OFF;
			sleep_q    <= 1'b0;
			strobe_q   <= 1'b0;
			hold_q     <= 1'b0;
			released_q <= 1'b0;
			lock_q     <= 1'b0;
			oe_q       <= 1'b0;
		end else begin
			state_q  <= state_d;
			lock_q   <= linked_d;
			oe_q     <= oe_d;
			settle_q <= (state_q == video_out_pkg::ST_STRAP) ? settle_q + 8'h01 : 8'h00;
			if (state_q == video_out_pkg::ST_STRAP && settle_done) begin
				mode_q   <= {blue_s[`STRAP_MODE_HI_BIT], blue_s[`STRAP_MODE_LO_BIT]};
				sleep_q  <= blue_s[`STRAP_SLEEP_BIT];
				strobe_q <= blue_s[`STRAP_EDGE_BIT];
				hold_q   <= hold_s;
			end
			if (state_q == video_out_pkg::ST_OFF) begin
				released_q <= 1'b0;
			end else if (hold_release) begin
				released_q <= 1'b1;
			end
		end
	end

	// Incoming pixel words are buffered so a burst from the receiver can wait.
	pix_stream_if #(.WIDTH(WW)) wr_if ();
	pix_stream_if #(.WIDTH(WW)) rd_if ();
	assign wr_if.valid = rx_valid;
	assign wr_if.data  = {rx_red, rx_green, rx_blue, rx_de, rx_hs, rx_vs};
	assign rx_ready    = wr_if.ready;
	// The FIFO drains at pixel rate even while asleep so stale video is not shown later.
	assign rd_if.ready = sel_edge;

	pixel_fifo #(.WIDTH(WW), .DEPTH(`PIX_FIFO_DEPTH)) u_fifo (
		.clock (clock),
		.nrst  (nrst),
		.wr    (wr_if.snk),
		.rd    (rd_if.src)
	);

	video_out_pkg::pixel_word_t head;
	assign head = rd_if.data;
	wire pop  = rd_if.valid & sel_edge;
	wire filt_on = (mode_q == `MODE_FILTER_ON);

	// Control filter for DE and HS: a level passes only after three held words.
	wire [1:0] ctl_raw = {head.de, head.hs};
	logic [1:0] ctl_out;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			logic       cand_q;
			logic       stable_q;
			logic [1:0] cnt_q;
			wire        same   = (ctl_raw[gi] == cand_q);
			wire        reach  = same && (cnt_q >= (`FILTER_MIN_WORDS - 2'h1));
			wire        filt_v = reach ? ctl_raw[gi] : stable_q;
			assign ctl_out[gi] = filt_on ? filt_v : ctl_raw[gi];
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					cand_q   <= 1'b0;
					stable_q <= 1'b0;
					cnt_q    <= 2'h0;
				end else if (pop) begin
					cand_q   <= ctl_raw[gi];
					stable_q <= filt_v;
					if (!same) begin
						cnt_q <= 2'h1;
					end else if (cnt_q != `FILTER_MIN_WORDS) begin
						cnt_q <= cnt_q + 2'h1;
					end
				end
			end
		end
	endgenerate

	// Output word and pixel clock; all fields move together on the chosen edge.
	video_out_pkg::pixel_word_t out_q;
	logic pclk_q;
	wire  active = (state_q == video_out_pkg::ST_ACTIVE);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_q  <= '0;
			pclk_q <= 1'b0;
		end else if (!active) begin
			out_q  <= '0;
			pclk_q <= 1'b0;
		end else begin
			pclk_q <= link_s;
			if (pop) begin
				out_q <= {head.red, head.green, head.blue, ctl_out[1], ctl_out[0], head.vs};
			end
		end
	end

	// Self-test: pass drops on any payload error; an error beats a restart.
	logic pass_q;
	logic bist_prev_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pass_q      <= 1'b1;
			bist_prev_q <= 1'b0;
		end else begin
			bist_prev_q <= bist_s;
			if (!bist_s) begin
				pass_q <= 1'b1;
			end else if (rx_error) begin
				pass_q <= 1'b0;
			end else if (!bist_prev_q) begin
				pass_q <= 1'b1;
			end
		end
	end

	// Pin mapping; bit 7 of each colour bus is its most significant bit.
	assign red_out            = out_q.red;
	assign green_out          = out_q.green;
	assign blue_out           = out_q.blue;
	assign red_oe             = {8{oe_q}};
	assign green_oe           = {8{oe_q}};
	assign blue_oe            = {8{oe_q}};
	assign video_valid_out    = out_q.de;
	assign line_sync_out      = out_q.hs;
	assign frame_sync_out     = out_q.vs;
	assign pixel_clock_out    = pclk_q;
	assign ctl_oe             = oe_q;
	assign lock_out           = lock_q;
	assign pass_out           = pass_q;
	assign op_mode            = mode_q;
	assign sleep_state_select = sleep_q;
	assign strobe_edge_select = strobe_q;

	// Checks on the logic above.
	a_pd_forces_off: assert property (@(posedge clock) disable iff (!nrst)
		!pd_s |=> state_q == video_out_pkg::ST_OFF && !lock_q ##1 out_q == '0)
		else $error("power-down did not force sleep");
	a_strap_pins_float: assert property (@(posedge clock) disable iff (!nrst)
		state_q == video_out_pkg::ST_STRAP |-> !oe_q && !red_oe[7] && !blue_oe[0])
		else $error("colour pins driven during strap sampling");
	// The settle count is too long to unroll, so the check rides on the settle counter.
	a_strap_wait_lock: assert property (@(posedge clock) disable iff (!nrst)
		state_q == video_out_pkg::ST_STRAP && pd_s
		|=> !lock_q && (state_q == video_out_pkg::ST_STRAP || $past(settle_done)))
		else $error("outputs left sleep before straps were sampled");
	a_unlock_drops: assert property (@(posedge clock) disable iff (!nrst)
		!pll_s |=> !lock_q ##1 out_q == '0 && pclk_q == 1'b0)
		else $error("unlocked but outputs not in sleep state");
	a_lock_needs_pll: assert property (@(posedge clock) disable iff (!nrst)
		$rose(lock_q) |-> $past(pll_s) && pd_s)
		else $error("lock raised without pll lock");
	a_hold_low_zero: assert property (@(posedge clock) disable iff (!nrst)
		state_q == video_out_pkg::ST_HOLD_LOW |=> out_q == '0 && oe_q && lock_q)
		else $error("hold-low state not driving low");
	a_launch_edge: assert property (@(posedge clock) disable iff (!nrst)
		active && $past(active) && $changed(out_q) |-> pclk_q == strobe_q)
		else $error("word changed away from the selected edge");
	a_filter_off_pass: assert property (@(posedge clock) disable iff (!nrst)
		active && pop && mode_q == `MODE_FILTER_OFF && state_d == state_q
		|=> video_valid_out == $past(head.de) && line_sync_out == $past(head.hs))
		else $error("unfiltered control level not passed");
	a_pass_drops: assert property (@(posedge clock) disable iff (!nrst)
		bist_s && $past(bist_s) && rx_error |=> !pass_q [*2] or (##1 !bist_s))
		else $error("self-test error did not clear pass");
	a_test_off_pass: assert property (@(posedge clock) disable iff (!nrst)
		!bist_s |=> pass_q)
		else $error("pass low with self-test disabled");
endmodule : deser_video_out

// file: hw/pixel_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module pixel_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 8
) (
	input  wire logic  clock,
	input  wire logic  nrst,
	pix_stream_if.snk  wr,
	pix_stream_if.src  rd
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW:0]      count_q;
	wire              push;
	wire              pop;

	// Full and empty come straight from the occupancy count.
	assign wr.ready = (count_q != (PW+1)'(DEPTH));
	assign rd.valid = (count_q != '0);
	assign rd.data  = mem_q[rd_ptr_q];
	assign push     = wr.valid & wr.ready;
	assign pop      = rd.valid & rd.ready;

	// Storage has no reset; only the pointers and the occupancy count define what is valid.
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= wr.data;
		end
	end

	// Pointers wrap; the depth is a power of two.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + PW'(push);
			rd_ptr_q <= rd_ptr_q + PW'(pop);
			count_q  <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : pixel_fifo

// file: pkg/pix_stream_if.sv
// Valid/ready stream of pixel words between the block's own modules.
`timescale 1ns/100ps
interface pix_stream_if #(
	parameter int WIDTH = 27
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : pix_stream_if

// file: pkg/video_out_defs.svh
// Constants for the deserializer video output block.
`ifndef VIDEO_OUT_DEFS_SVH
`define VIDEO_OUT_DEFS_SVH

// Core clock period and strap settle time, both in nanoseconds.
`define CLK_PERIOD_NS       4
`define STRAP_SETTLE_NS     100
// Least settle time rounds up to whole clock cycles.
`define STRAP_SETTLE_CYC    ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Strap positions on the blue colour pins.
`define STRAP_MODE_HI_BIT   6
`define STRAP_MODE_LO_BIT   7
`define STRAP_SLEEP_BIT     2
`define STRAP_EDGE_BIT      1

// Operating mode codes.
`define MODE_FILTER_OFF     2'h0
`define MODE_FILTER_ON      2'h1
`define MODE_LEGACY_A       2'h2
`define MODE_LEGACY_B       2'h3

// Least number of pixel words a filtered control level must hold.
`define FILTER_MIN_WORDS    2'h3

// Output FIFO depth in pixel words.
`define PIX_FIFO_DEPTH      8

`endif

// file: pkg/video_out_pkg.sv
// Types shared by the deserializer video output block.
package video_out_pkg;

	// One pixel word: colour plus the three control levels.
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
		logic       de;
		logic       hs;
		logic       vs;
	} pixel_word_t;

	// Output sequencer states.
	typedef enum logic [2:0] {
		ST_OFF,
		ST_STRAP,
		ST_WAIT_LOCK,
		ST_HOLD_LOW,
		ST_ACTIVE
	} ctl_state_t;

endpackage : video_out_pkg
